// *** logic/dram_mode_pkg.sv ***
package dram_mode_pkg;
	localparam logic [5:0] ADDR_INFO        = 6'h00;
	localparam logic [5:0] ADDR_FEATURE_ONE = 6'h01;
	localparam logic [5:0] ADDR_REG_CONTROL = 6'h0d;
	// info register field positions
	localparam int INFO_REFRESH_BIT  = 0;
	localparam int INFO_LATENCY_BIT  = 1;
	localparam int INFO_ZQ_LO        = 3;
	// feature and control register field positions
	localparam int FEAT_BL_LO        = 0;
	localparam int FEAT_WPRE_BIT     = 2;
	localparam int FEAT_RPRE_BIT     = 3;
	localparam int FEAT_WR_LO        = 4;
	localparam int FEAT_PST_BIT      = 7;
	localparam int CTRL_WR_SEL_BIT   = 6;
	localparam int CTRL_OP_SEL_BIT   = 7;
	// reset values of a set-point copy: bl16, 2-clock write preamble, static, nwr 6, 0.5 pst
	localparam logic [7:0] FEATURE_RESET = 8'h04;
	localparam logic [7:0] CTRL_RESET    = 8'h00;
	// self-test result codes
	localparam logic [1:0] ZQ_NONE  = 2'h0;
	localparam logic [1:0] ZQ_LOW   = 2'h1;
	localparam logic [1:0] ZQ_HIGH  = 2'h2;
	localparam logic [1:0] ZQ_GOOD  = 2'h3;
	// burst length codes
	localparam logic [1:0] BL_16    = 2'h0;
	localparam logic [1:0] BL_32    = 2'h1;
	localparam logic [1:0] BL_OTF   = 2'h2;
	localparam logic [5:0] BURST_16 = 6'h10;
	localparam logic [5:0] BURST_32 = 6'h20;
	// latch wait, cycles (arbitrary default)
	localparam logic [7:0] CALIB_LATCH_WAIT = 8'h0a;
	typedef enum logic [2:0] {
		CAL_IDLE    = 3'b001,
		CAL_STARTED = 3'b010,
		CAL_WAIT    = 3'b100
	} cal_state_t;
endpackage : dram_mode_pkg

// *** logic/dram_feature_mode_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module dram_feature_mode_regs (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       arst_n,
	// device straps
	input  wire logic       refresh_modified_only,
	input  wire logic       latency_byte_mode,
	input  wire logic       zq_selftest_supported,
	input  wire logic [1:0] zq_pin_status,
	// mode register commands
	input  wire logic       mode_reg_write_cmd,
	input  wire logic       mode_reg_read_cmd,
	input  wire logic [5:0] mode_addr,
	input  wire logic [7:0] mode_wdata,
	output logic [7:0]      mode_rdata,
	output logic            mode_rvalid,
	// calibration commands
	input  wire logic       calib_start_cmd,
	input  wire logic       calib_latch_cmd,
	output logic            zq_result_valid,
	output logic            factory_trim_sel,
	output logic            calib_cmd_accept,
	// write with auto precharge
	input  wire logic       write_done_ap,
	output logic            precharge_start,
	// burst
	input  wire logic       cmd_burst_bit,
	output logic [5:0]      burst_len,
	// active operating fields
	output logic [1:0]      burst_len_sel,
	output logic            write_preamble_long,
	output logic            read_preamble_toggle,
	output logic [2:0]      write_recovery_code,
	output logic [5:0]      write_recovery_count,
	output logic            read_postamble_len,
	output logic            setpoint_write_sel,
	output logic            setpoint_operate_sel
);
	// pin synchronisers
	logic [1:0] strap_m_q, strap_q, strap_m_d;
	logic [2:0] zq_m_q, zq_q, zq_m_d;

	// set-point copies and control
	logic [7:0] feat_q [2];
	logic [7:0] feat_d [2];
	logic [7:0] ctrl_q, ctrl_d;

	// self-test result and calibration sequence
	logic [1:0] zq_res_q, zq_res_d;
	logic       valid_q, valid_d;
	dram_mode_pkg::cal_state_t cal_q, cal_d;
	logic [7:0] wait_q, wait_d;

	// recovery counter
	logic [5:0] wr_cnt_q, wr_cnt_d;
	logic       wr_busy_q, wr_busy_d;
	logic       pc_q, pc_d;

	// read answer
	logic [7:0] rdata_q, rdata_d;
	logic       rvalid_q, rvalid_d;
	logic [7:0] act;
	logic       asm_err;

	// straps arrive from pins: two flops before use
	assign strap_m_d = {latency_byte_mode, refresh_modified_only};
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			strap_m_q <= 2'h0;
			strap_q   <= 2'h0;
		end else begin
			strap_m_q <= strap_m_d;
			strap_q   <= strap_m_q;
		end
	end

	// self-test pin code: levels, settled long before any latch samples them
	assign zq_m_d = {zq_selftest_supported, zq_pin_status};
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			zq_m_q <= 3'h0;
			zq_q   <= 3'h0;
		end else begin
			zq_m_q <= zq_m_d;
			zq_q   <= zq_m_q;
		end
	end

	// set-point registers
	// control writes take effect on the next edge for both selects
	always_comb begin
		ctrl_d = ctrl_q;
		for (int i = 0; i < 2; i++) begin
			feat_d[i] = feat_q[i];
		end
		if (mode_reg_write_cmd) begin
			if (mode_addr == dram_mode_pkg::ADDR_FEATURE_ONE) begin
				feat_d[ctrl_q[dram_mode_pkg::CTRL_WR_SEL_BIT]] = mode_wdata;
			end else if (mode_addr == dram_mode_pkg::ADDR_REG_CONTROL) begin
				ctrl_d = mode_wdata;
			end
			// an info write falls through untouched
		end
	end

	// the inactive copy feeds nothing, so it may be rewritten while running
	assign act = feat_q[ctrl_q[dram_mode_pkg::CTRL_OP_SEL_BIT]];
	assign setpoint_write_sel   = ctrl_q[dram_mode_pkg::CTRL_WR_SEL_BIT];
	assign setpoint_operate_sel = ctrl_q[dram_mode_pkg::CTRL_OP_SEL_BIT];
	assign burst_len_sel        = act[dram_mode_pkg::FEAT_BL_LO +: 2];
	assign write_preamble_long  = act[dram_mode_pkg::FEAT_WPRE_BIT];
	assign read_preamble_toggle = act[dram_mode_pkg::FEAT_RPRE_BIT];
	assign write_recovery_code  = act[dram_mode_pkg::FEAT_WR_LO +: 3];
	assign read_postamble_len   = act[dram_mode_pkg::FEAT_PST_BIT];

	// write recovery table
	// every code is legal, so no default
	always_comb begin
		unique case (write_recovery_code)
			3'h0: write_recovery_count = 6'd6;
			3'h1: write_recovery_count = 6'd10;
			3'h2: write_recovery_count = 6'd16;
			3'h3: write_recovery_count = 6'd20;
			3'h4: write_recovery_count = 6'd24;
			3'h5: write_recovery_count = 6'd30;
			3'h6: write_recovery_count = 6'd34;
			3'h7: write_recovery_count = 6'd40;
		endcase
	end

	// burst length per access
	// reserved code falls back to 16 rather than leaving the length undefined
	always_comb begin
		unique case (burst_len_sel)
			dram_mode_pkg::BL_32:  burst_len = dram_mode_pkg::BURST_32;
			dram_mode_pkg::BL_OTF: begin
				if (cmd_burst_bit) begin
					burst_len = dram_mode_pkg::BURST_32;
				end else begin
					burst_len = dram_mode_pkg::BURST_16;
				end
			end
			default:               burst_len = dram_mode_pkg::BURST_16;
		endcase
	end

	// zq self-test and calibration
	// trim follows the latched result, not the live pin, so a later pin change cannot flip it
	assign asm_err = (zq_res_q == dram_mode_pkg::ZQ_LOW) || (zq_res_q == dram_mode_pkg::ZQ_HIGH);
	assign factory_trim_sel = valid_q && asm_err;
	assign calib_cmd_accept = !factory_trim_sel && (calib_start_cmd || calib_latch_cmd);
	assign zq_result_valid  = valid_q;

	always_comb begin
		cal_d    = cal_q;
		wait_d   = wait_q;
		zq_res_d = zq_res_q;
		valid_d  = valid_q;
		unique case (cal_q)
			dram_mode_pkg::CAL_IDLE: begin
				if (calib_start_cmd && !factory_trim_sel) begin
					cal_d = dram_mode_pkg::CAL_STARTED;
				end
			end
			// a latch with no start before it is dropped
			dram_mode_pkg::CAL_STARTED: begin
				if (calib_latch_cmd) begin
					cal_d  = dram_mode_pkg::CAL_WAIT;
					wait_d = dram_mode_pkg::CALIB_LATCH_WAIT;
				end
			end
			dram_mode_pkg::CAL_WAIT: begin
				if (wait_q == 8'h00) begin
					cal_d    = dram_mode_pkg::CAL_IDLE;
					valid_d  = 1'b1;
					zq_res_d = zq_q[2] ? zq_q[1:0] : dram_mode_pkg::ZQ_NONE;
				end else begin
					wait_d = wait_q - 8'h01;
				end
			end
			default: cal_d = dram_mode_pkg::CAL_IDLE;
		endcase
	end

	// auto precharge write recovery
	// loaded with one less than the count; the pulse leaves write_recovery_count edges after the done edge
	// a fresh done restarts the count rather than queueing a second precharge
	always_comb begin
		wr_cnt_d  = wr_cnt_q;
		wr_busy_d = wr_busy_q;
		pc_d      = 1'b0;
		if (write_done_ap) begin
			wr_busy_d = 1'b1;
			wr_cnt_d  = write_recovery_count - 6'd1;
		end else if (wr_busy_q) begin
			if (wr_cnt_q == 6'd0) begin
				wr_busy_d = 1'b0;
				pc_d      = 1'b1;
			end else begin
				wr_cnt_d = wr_cnt_q - 6'd1;
			end
		end
	end

	// mode register read
	// straps show up here two edges after they settle
	always_comb begin
		rvalid_d = mode_reg_read_cmd;
		rdata_d  = rdata_q;
		if (mode_reg_read_cmd) begin
			rdata_d = 8'h00;
			if (mode_addr == dram_mode_pkg::ADDR_INFO) begin
				rdata_d[dram_mode_pkg::INFO_REFRESH_BIT] = strap_q[0];
				rdata_d[dram_mode_pkg::INFO_LATENCY_BIT] = strap_q[1];
				rdata_d[dram_mode_pkg::INFO_ZQ_LO +: 2]  = valid_q ? zq_res_q
				                                                   : dram_mode_pkg::ZQ_NONE;
			end
			// write-only addresses answer zero here, which is allowed
		end
	end
	assign mode_rdata  = rdata_q;
	assign mode_rvalid = rvalid_q;
	assign precharge_start = pc_q;

	// set-point copies, one register each
	for (genvar g = 0; g < 2; g++) begin : g_setpoint
		always_ff @(posedge clk or negedge arst_n) begin
			if (!arst_n) begin
				feat_q[g] <= dram_mode_pkg::FEATURE_RESET;
			end else begin
				feat_q[g] <= feat_d[g];
			end
		end
	end

	// register control
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_q <= dram_mode_pkg::CTRL_RESET;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// reset drops the self-test result; only a new calibration brings it back
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			zq_res_q <= dram_mode_pkg::ZQ_NONE;
			valid_q  <= 1'b0;
			cal_q    <= dram_mode_pkg::CAL_IDLE;
			wait_q   <= 8'h00;
		end else begin
			zq_res_q <= zq_res_d;
			valid_q  <= valid_d;
			cal_q    <= cal_d;
			wait_q   <= wait_d;
		end
	end

	// recovery counter and precharge pulse
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_cnt_q  <= 6'h00;
			wr_busy_q <= 1'b0;
			pc_q      <= 1'b0;
		end else begin
			wr_cnt_q  <= wr_cnt_d;
			wr_busy_q <= wr_busy_d;
			pc_q      <= pc_d;
		end
	end

	// read answer
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_q  <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			rdata_q  <= rdata_d;
			rvalid_q <= rvalid_d;
		end
	end
endmodule : dram_feature_mode_regs
`default_nettype wire

// *** testbench/dram_feature_mode_regs_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module dram_feature_mode_regs_chk (
	input wire logic       clk, arst_n, mode_reg_write_cmd, mode_reg_read_cmd,
	input wire logic [5:0] mode_addr, burst_len, write_recovery_count,
	input wire logic [7:0] mode_wdata, mode_rdata,
	input wire logic       mode_rvalid, factory_trim_sel, calib_cmd_accept,
	input wire logic       write_done_ap, precharge_start, cmd_burst_bit,
	input wire logic [1:0] burst_len_sel,
	input wire logic [2:0] write_recovery_code,
	input wire logic       setpoint_write_sel, setpoint_operate_sel
);
	localparam logic [5:0] WRITE_RECOVERY_COUNT [8] = '{6'h06, 6'h0a, 6'h10, 6'h14, 6'h18, 6'h1e, 6'h22, 6'h28};
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	AST_RVALID: assert property (mode_rvalid == $past(mode_reg_read_cmd))
		else $error("read answer timing");
	AST_INFO_RSV: assert property (mode_reg_read_cmd && mode_addr == 6'h00 |=>
		mode_rdata[7:5] == 3'h0 && !mode_rdata[2]) else $error("reserved info bits");
	AST_WO_READ: assert property (mode_reg_read_cmd && mode_addr == 6'h01 |=>
		mode_rdata == 8'h00) else $error("feature read data");
	AST_BL32: assert property (burst_len_sel == 2'h1 |-> burst_len == 6'h20)
		else $error("fixed burst 32");
	AST_OTF: assert property (burst_len_sel == 2'h2 |->
		burst_len == (cmd_burst_bit ? 6'h20 : 6'h10)) else $error("on-the-fly burst");
	AST_NWR: assert property (write_recovery_count == WRITE_RECOVERY_COUNT[write_recovery_code])
		else $error("write recovery map");
	AST_TRIM: assert property (factory_trim_sel |-> !calib_cmd_accept)
		else $error("calibration accepted on assembly error");
	AST_RO_WR: assert property (mode_reg_write_cmd && mode_addr == 6'h00 |=>
		$stable(burst_len_sel) && $stable(write_recovery_code)) else $error("info write");
	AST_INACTIVE: assert property (mode_reg_write_cmd && mode_addr == 6'h01 &&
		setpoint_write_sel != setpoint_operate_sel |=> $stable(burst_len_sel))
		else $error("inactive copy disturbed");
	AST_ACTIVE: assert property (mode_reg_write_cmd && mode_addr == 6'h01 &&
		setpoint_write_sel == setpoint_operate_sel |=> burst_len_sel == $past(mode_wdata[1:0]))
		else $error("active copy not written");
	AST_PRECHG: assert property (write_done_ap && write_recovery_count == 6'h06
		##1 !write_done_ap [*7] |-> precharge_start) else $error("precharge timing");
endmodule : dram_feature_mode_regs_chk
bind dram_feature_mode_regs dram_feature_mode_regs_chk chk (.*);
`default_nettype wire

// *** testbench/mode_ctrl_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module mode_ctrl_model (
	input  wire logic clk,
	output logic      mode_reg_write_cmd, mode_reg_read_cmd, calib_start_cmd, calib_latch_cmd,
	output logic [5:0] mode_addr,
	output logic [7:0] mode_wdata
);
	initial {mode_reg_write_cmd, mode_reg_read_cmd, calib_start_cmd, calib_latch_cmd} = 4'h0;
	initial {mode_addr, mode_wdata} = 14'h0000;
	task automatic cmd(input logic w, input logic r, input logic [5:0] a, input logic [7:0] d);
		@(posedge clk);
		mode_reg_write_cmd <= w;
		mode_reg_read_cmd <= r;
		mode_addr <= a;
		mode_wdata <= (a == 6'h01) ? (d | 8'h04) : d;
		@(posedge clk);
		mode_reg_write_cmd <= 1'b0;
		mode_reg_read_cmd <= 1'b0;
		// released bus shows garbage, not the old value
		mode_addr <= ~a;
		mode_wdata <= ~d;
	endtask : cmd
	task automatic calibrate();
		@(posedge clk);
		calib_start_cmd <= 1'b1;
		@(posedge clk);
		calib_start_cmd <= 1'b0;
		calib_latch_cmd <= 1'b1;
		@(posedge clk);
		calib_latch_cmd <= 1'b0;
		repeat (int'(dram_mode_pkg::CALIB_LATCH_WAIT) + 4) @(posedge clk);
	endtask : calibrate
endmodule : mode_ctrl_model
`default_nettype wire

// *** testbench/dram_feature_mode_regs_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module dram_feature_mode_regs_test;
	typedef struct {logic [7:0] w; logic [5:0] n;} row_t;
	logic       clk, arst_n, refresh_modified_only, latency_byte_mode, zq_selftest_supported;
	logic [1:0] zq_pin_status, burst_len_sel;
	logic       mode_reg_write_cmd, mode_reg_read_cmd, calib_start_cmd, calib_latch_cmd;
	logic [5:0] mode_addr, burst_len, write_recovery_count;
	logic [7:0] mode_wdata, mode_rdata, w;
	logic       mode_rvalid, zq_result_valid, factory_trim_sel, calib_cmd_accept, write_done_ap;
	logic       precharge_start, cmd_burst_bit, write_preamble_long, read_preamble_toggle;
	logic [2:0] write_recovery_code;
	logic       read_postamble_len, setpoint_write_sel, setpoint_operate_sel;
	int         fails, total_checks, n;
	row_t rows [8] = '{'{8'h04, 6'h06}, '{8'h15, 6'h0a}, '{8'h2e, 6'h10}, '{8'h34, 6'h14},
		'{8'hc4, 6'h18}, '{8'h54, 6'h1e}, '{8'h6c, 6'h22}, '{8'hf6, 6'h28}};
	dram_feature_mode_regs dut (.*);
	mode_ctrl_model ctrl (.clk, .mode_reg_write_cmd, .mode_reg_read_cmd, .calib_start_cmd,
		.calib_latch_cmd, .mode_addr, .mode_wdata);
	task automatic check(input logic ok, input string what);
		total_checks++;
		if (ok !== 1'b1) begin
			fails++;
			$display("[FAIL] %0t %s", $time, what);
		end
	endtask : check
	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		ctrl.cmd(1'b0, 1'b1, a, 8'h00);
		#1 check(mode_rvalid === 1'b1 && mode_rdata === e, "read data");
	endtask : rd
	task automatic print_verdict();
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : print_verdict
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		repeat (4000) @(posedge clk);
		fails++;
		print_verdict();
	end
	initial begin
		{arst_n, write_done_ap} = 2'h0;
		{refresh_modified_only, latency_byte_mode, zq_selftest_supported, cmd_burst_bit} = 4'hf;
		zq_pin_status = dram_mode_pkg::ZQ_GOOD;
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		write_done_ap <= 1'b1;
		@(posedge clk);
		write_done_ap <= 1'b0;
		n = 0;
		while (precharge_start !== 1'b1 && n < 60) begin
			@(posedge clk);
			#1 n++;
		end
		check(n == 6, "precharge delay");
		foreach (rows[i]) begin
			w = rows[i].w;
			ctrl.cmd(1'b1, 1'b0, dram_mode_pkg::ADDR_FEATURE_ONE, w);
			#1 check({burst_len_sel, write_preamble_long, read_preamble_toggle, write_recovery_code,
				read_postamble_len} === {w[1:0], w[2], w[3], w[6:4], w[7]}, "fields");
			check(write_recovery_count === rows[i].n, "recovery count");
			check(burst_len === (w[1:0] == 2'h0 ? 6'h10 : 6'h20), "burst");
		end
		rd(dram_mode_pkg::ADDR_FEATURE_ONE, 8'h00);
		rd(6'h3f, 8'h00);
		rd(dram_mode_pkg::ADDR_INFO, 8'h03);
		ctrl.cmd(1'b1, 1'b0, dram_mode_pkg::ADDR_INFO, 8'hff);
		rd(dram_mode_pkg::ADDR_INFO, 8'h03);
		ctrl.calibrate();
		rd(dram_mode_pkg::ADDR_INFO, 8'h1b);
		check(zq_result_valid === 1'b1 && factory_trim_sel === 1'b0, "result valid");
		ctrl.cmd(1'b1, 1'b0, dram_mode_pkg::ADDR_REG_CONTROL, 8'h40);
		ctrl.cmd(1'b1, 1'b0, dram_mode_pkg::ADDR_FEATURE_ONE, 8'h15);
		#1 check(burst_len_sel === 2'h2, "inactive copy");
		check(setpoint_write_sel === 1'b1 && setpoint_operate_sel === 1'b0, "selects");
		ctrl.cmd(1'b1, 1'b0, dram_mode_pkg::ADDR_REG_CONTROL, 8'h80);
		#1 check(burst_len_sel === 2'h1 && write_recovery_count === 6'h0a, "active copy");
		@(posedge clk);
		arst_n <= 1'b0;
		zq_pin_status <= dram_mode_pkg::ZQ_LOW;
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd(dram_mode_pkg::ADDR_INFO, 8'h03);
		check(zq_result_valid === 1'b0, "result lost on reset");
		ctrl.calibrate();
		rd(dram_mode_pkg::ADDR_INFO, 8'h0b);
		check(factory_trim_sel === 1'b1, "factory trim");
		ctrl.calibrate();
		rd(dram_mode_pkg::ADDR_INFO, 8'h0b);
		check(zq_result_valid === 1'b1 && factory_trim_sel === 1'b1, "trim kept");
		print_verdict();
	end
endmodule : dram_feature_mode_regs_test
`default_nettype wire
